// ### pkg/hbs_pkg.sv
package hbs_pkg;

	////////////////////////////////////////////////////////////////////////
	// time base: one millisecond tick from the system clock
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// brake configuration codes
	localparam logic [1:0] CFG_NONE = 2'h0;
	localparam logic [1:0] CFG_SEQ = 2'h1;
	localparam logic [1:0] CFG_OPEN = 2'h2;
	localparam logic [1:0] CFG_RSVD = 2'h3;
	localparam logic [1:0] CFG_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// delay fields, in milliseconds
	localparam int DLY_W = 14;
	localparam int CNT_W = 15;
	localparam logic [13:0] DLY_MAX = 14'h2710;
	localparam logic [13:0] OPEN_DLY_RESET = 14'h0064;
	localparam logic [13:0] CLOSE_DLY_RESET = 14'h0064;
	localparam logic [13:0] ZS_MON_RESET = 14'h00c8;
	localparam logic [13:0] PULSE_SUP_RESET = 14'h0064;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_OPEN_DLY = 8'h04;
	localparam logic [7:0] OFS_CLOSE_DLY = 8'h08;
	localparam logic [7:0] OFS_ZS_MON = 8'h0c;
	localparam logic [7:0] OFS_PULSE_SUP = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// status register bit positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_SERVO_ON = 4;
	localparam int ST_BRAKE = 5;
	localparam int ST_POWER = 6;
	localparam int ST_MOTION = 7;

	////////////////////////////////////////////////////////////////////////
	// sequence states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_OPENING = 3'b001,
		S_RUN = 3'b010,
		S_STOPPING = 3'b011,
		S_CLOSING = 3'b100
	} hbs_state_t;

endpackage : hbs_pkg

// ### design/hbs_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; the level moves once stages two and three agree
module hbs_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);

	logic s1_r, s2_r, s3_r, lvl_r;
	logic lvl_nxt;

	// stage one is seen only by stage two
	always_comb begin
		lvl_nxt = lvl_r;
		if (s2_r == s3_r) begin
			lvl_nxt = s3_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign dout = lvl_r;

endmodule : hbs_sync

// ### design/hbs_ms_tick.sv
`timescale 1ns/10ps
// millisecond prescaler; clear restarts the phase so delays start exact
module hbs_ms_tick #(
	parameter int CYCLES = hbs_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	output logic tick
);

	logic [31:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		cnt_nxt = cnt_r + 32'h1;
		tick_nxt = 1'b0;
		if (clr) begin
			cnt_nxt = 32'h0;
		end else if (cnt_r >= 32'(CYCLES - 1)) begin
			cnt_nxt = 32'h0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule : hbs_ms_tick

// ### design/hbs_brake_seq.sv
`timescale 1ns/10ps
module hbs_brake_seq #(
	parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic SERVO_ON_INPUT,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic BRAKE_HOLD_OUTPUT,
	output logic MOTOR_POWER_ON,
	output logic MOTION_ENABLE
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic servo_on;
	logic ms_tick;
	logic tick_clr;
	logic servo_d_r, servo_d_nxt;
	logic servo_rise, servo_fall;
	logic [1:0] brake_config_code_r, brake_config_code_nxt;
	logic [13:0] brake_open_delay_r, brake_open_delay_nxt;
	logic [13:0] brake_close_delay_r, brake_close_delay_nxt;
	logic [13:0] zero_speed_monitor_time_r, zero_speed_monitor_time_nxt;
	logic [13:0] pulse_suppress_delay_r, pulse_suppress_delay_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [13:0] wr_dly;
	hbs_pkg::hbs_state_t state_r, state_nxt;
	logic [14:0] ms_cnt_r, ms_cnt_nxt;
	logic [13:0] limit;
	logic done;
	logic brake_r, brake_nxt;
	logic power_r, power_nxt;
	logic motion_r, motion_nxt;

	////////////////////////////////////////////////////////////////////////
	// servo-on arrives from a pin, so it is synchronised first
	hbs_sync u_servo_sync (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.din(SERVO_ON_INPUT),
		.dout(servo_on)
	);

	// delay time base, rephased on every state change
	hbs_ms_tick #(
		.CYCLES(TICK_CYCLES)
	) u_ms_tick (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.clr(tick_clr),
		.tick(ms_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// register file
	// delay writes above the 10000 ms ceiling are clamped, not wrapped
	always_comb begin
		wr_dly = REG_WDATA[13:0];
		if (REG_WDATA[31:14] != 18'h0 || REG_WDATA[13:0] > hbs_pkg::DLY_MAX) begin
			wr_dly = hbs_pkg::DLY_MAX;
		end
	end

	// write decode; unmapped and status writes are dropped
	always_comb begin
		brake_config_code_nxt = brake_config_code_r;
		brake_open_delay_nxt = brake_open_delay_r;
		brake_close_delay_nxt = brake_close_delay_r;
		zero_speed_monitor_time_nxt = zero_speed_monitor_time_r;
		pulse_suppress_delay_nxt = pulse_suppress_delay_r;
		if (REG_WR) begin
			case (REG_ADDR)
				hbs_pkg::OFS_CONFIG: begin
					brake_config_code_nxt = REG_WDATA[1:0];
				end
				hbs_pkg::OFS_OPEN_DLY: begin
					brake_open_delay_nxt = wr_dly;
				end
				hbs_pkg::OFS_CLOSE_DLY: begin
					brake_close_delay_nxt = wr_dly;
				end
				hbs_pkg::OFS_ZS_MON: begin
					zero_speed_monitor_time_nxt = wr_dly;
				end
				hbs_pkg::OFS_PULSE_SUP: begin
					pulse_suppress_delay_nxt = wr_dly;
				end
				default: begin
				end
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = 32'h0;
		if (REG_RD) begin
			case (REG_ADDR)
				hbs_pkg::OFS_CONFIG: rdata_nxt[1:0] = brake_config_code_r;
				hbs_pkg::OFS_OPEN_DLY: rdata_nxt[13:0] = brake_open_delay_r;
				hbs_pkg::OFS_CLOSE_DLY: rdata_nxt[13:0] = brake_close_delay_r;
				hbs_pkg::OFS_ZS_MON: rdata_nxt[13:0] = zero_speed_monitor_time_r;
				hbs_pkg::OFS_PULSE_SUP: rdata_nxt[13:0] = pulse_suppress_delay_r;
				hbs_pkg::OFS_STATUS: begin
					rdata_nxt[hbs_pkg::ST_STATE_LSB +: 3] = state_r;
					rdata_nxt[hbs_pkg::ST_SERVO_ON] = servo_on;
					rdata_nxt[hbs_pkg::ST_BRAKE] = brake_r;
					rdata_nxt[hbs_pkg::ST_POWER] = power_r;
					rdata_nxt[hbs_pkg::ST_MOTION] = motion_r;
				end
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			brake_config_code_r <= hbs_pkg::CFG_RESET;
			brake_open_delay_r <= hbs_pkg::OPEN_DLY_RESET;
			brake_close_delay_r <= hbs_pkg::CLOSE_DLY_RESET;
			zero_speed_monitor_time_r <= hbs_pkg::ZS_MON_RESET;
			pulse_suppress_delay_r <= hbs_pkg::PULSE_SUP_RESET;
			rdata_r <= 32'h0;
		end else begin
			brake_config_code_r <= brake_config_code_nxt;
			brake_open_delay_r <= brake_open_delay_nxt;
			brake_close_delay_r <= brake_close_delay_nxt;
			zero_speed_monitor_time_r <= zero_speed_monitor_time_nxt;
			pulse_suppress_delay_r <= pulse_suppress_delay_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// servo-on edges, taken from the synchronised level
	assign servo_d_nxt = servo_on;
	assign servo_rise = servo_on & ~servo_d_r;
	assign servo_fall = ~servo_on & servo_d_r;

	// delay that applies to the current state
	always_comb begin
		limit = 14'h0;
		case (state_r)
			hbs_pkg::S_OPENING: limit = brake_open_delay_r;
			hbs_pkg::S_CLOSING: limit = brake_close_delay_r;
			hbs_pkg::S_STOPPING: begin
				// the shorter timer wins
				if (zero_speed_monitor_time_r < pulse_suppress_delay_r) begin
					limit = zero_speed_monitor_time_r;
				end else begin
					limit = pulse_suppress_delay_r;
				end
			end
			default: limit = 14'h0;
		endcase
	end

	assign done = ms_cnt_r >= {1'b0, limit};

	////////////////////////////////////////////////////////////////////////
	// sequence state machine
	// edges that come while stopping or closing are not queued
	always_comb begin
		state_nxt = state_r;
		if (brake_config_code_r != hbs_pkg::CFG_SEQ) begin
			state_nxt = hbs_pkg::S_IDLE;
		end else begin
			case (state_r)
				hbs_pkg::S_IDLE: begin
					if (servo_rise) begin
						state_nxt = hbs_pkg::S_OPENING;
					end
				end
				hbs_pkg::S_OPENING: begin
					if (servo_fall) begin
						state_nxt = hbs_pkg::S_STOPPING;
					end else if (done) begin
						state_nxt = hbs_pkg::S_RUN;
					end
				end
				hbs_pkg::S_RUN: begin
					if (servo_fall) begin
						state_nxt = hbs_pkg::S_STOPPING;
					end
				end
				hbs_pkg::S_STOPPING: begin
					if (done) begin
						state_nxt = hbs_pkg::S_CLOSING;
					end
				end
				hbs_pkg::S_CLOSING: begin
					if (done) begin
						state_nxt = hbs_pkg::S_IDLE;
					end
				end
				default: state_nxt = hbs_pkg::S_IDLE;
			endcase
		end
	end

	// millisecond counter since state entry, saturating
	assign tick_clr = state_nxt != state_r;

	always_comb begin
		ms_cnt_nxt = ms_cnt_r;
		if (tick_clr) begin
			ms_cnt_nxt = 15'h0;
		end else if (ms_tick && ms_cnt_r != 15'h7fff) begin
			ms_cnt_nxt = ms_cnt_r + 15'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// in the sequence config outputs follow the next state so they change with it; the other configs fix the brake, and power and motion follow servo-on
	always_comb begin
		brake_nxt = 1'b1;
		power_nxt = 1'b0;
		motion_nxt = 1'b0;
		case (brake_config_code_r)
			hbs_pkg::CFG_SEQ: begin
				case (state_nxt)
					hbs_pkg::S_OPENING: begin
						brake_nxt = 1'b0;
						power_nxt = 1'b1;
					end
					hbs_pkg::S_RUN: begin
						brake_nxt = 1'b0;
						power_nxt = 1'b1;
						motion_nxt = 1'b1;
					end
					hbs_pkg::S_STOPPING: begin
						brake_nxt = 1'b0;
						power_nxt = 1'b1;
					end
					hbs_pkg::S_CLOSING: begin
						brake_nxt = 1'b1;
						power_nxt = 1'b1;
					end
					default: begin
						brake_nxt = 1'b1;
					end
				endcase
			end
			hbs_pkg::CFG_OPEN: begin
				brake_nxt = 1'b0;
				power_nxt = servo_on;
				motion_nxt = servo_on;
			end
			default: begin
				// no brake fitted or reserved: output idles closed
				brake_nxt = 1'b1;
				power_nxt = servo_on;
				motion_nxt = servo_on;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_r <= hbs_pkg::S_IDLE;
			ms_cnt_r <= 15'h0;
			servo_d_r <= 1'b0;
			brake_r <= 1'b1;
			power_r <= 1'b0;
			motion_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ms_cnt_r <= ms_cnt_nxt;
			servo_d_r <= servo_d_nxt;
			brake_r <= brake_nxt;
			power_r <= power_nxt;
			motion_r <= motion_nxt;
		end
	end

	assign REG_RDATA = rdata_r;
	assign BRAKE_HOLD_OUTPUT = brake_r;
	assign MOTOR_POWER_ON = power_r;
	assign MOTION_ENABLE = motion_r;

endmodule : hbs_brake_seq

// ### test/hbs_brake_seq_sva.sv
`timescale 1ns/10ps
// port checker; config is shadowed from the register writes
module hbs_brake_seq_sva #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic SERVO_ON_INPUT,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic BRAKE_HOLD_OUTPUT,
	input wire logic MOTOR_POWER_ON,
	input wire logic MOTION_ENABLE
);
	logic [1:0] cfg_r;
	logic [1:0] cfg_nxt;
	logic [1:0] age_r;
	logic [1:0] age_nxt;
	logic calm;
	logic seq;
	////////////////////////////////////////////////////////////////////////
	// age lets the outputs settle before a new config is judged
	always_comb begin
		cfg_nxt = cfg_r;
		age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
		if (REG_WR && REG_ADDR == hbs_pkg::OFS_CONFIG) begin
			cfg_nxt = REG_WDATA[1:0];
			age_nxt = 2'h0;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cfg_r <= hbs_pkg::CFG_RESET;
			age_r <= 2'h3;
		end else begin
			cfg_r <= cfg_nxt;
			age_r <= age_nxt;
		end
	end
	assign calm = (age_r == 2'h3);
	assign seq = calm && (cfg_r == hbs_pkg::CFG_SEQ);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////////////
	property p_open_cfg;
		calm && cfg_r == hbs_pkg::CFG_OPEN |-> !BRAKE_HOLD_OUTPUT;
	endproperty
	a_open_cfg: assert property (p_open_cfg)
		else $error("brake closed in open config");
	property p_none_cfg;
		calm && !cfg_r[0] && !cfg_r[1] || calm && &cfg_r
			|-> BRAKE_HOLD_OUTPUT;
	endproperty
	a_none_cfg: assert property (p_none_cfg)
		else $error("brake released without brake config");
	property p_rise;
		seq && $rose(MOTOR_POWER_ON) |-> !BRAKE_HOLD_OUTPUT && !MOTION_ENABLE;
	endproperty
	a_rise: assert property (p_rise)
		else $error("power on without release");
	property p_motion;
		seq && MOTION_ENABLE |-> !BRAKE_HOLD_OUTPUT && MOTOR_POWER_ON;
	endproperty
	a_motion: assert property (p_motion)
		else $error("motion with brake or no power");
	property p_power_off;
		seq && $fell(MOTOR_POWER_ON) |-> BRAKE_HOLD_OUTPUT && $past(BRAKE_HOLD_OUTPUT);
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("power removed before brake");
	property p_close;
		seq && $rose(BRAKE_HOLD_OUTPUT) |-> MOTOR_POWER_ON && !$past(MOTION_ENABLE);
	endproperty
	a_close: assert property (p_close)
		else $error("brake closed out of order");
	property p_stop;
		seq && $fell(MOTION_ENABLE) |-> !BRAKE_HOLD_OUTPUT ##1 MOTOR_POWER_ON;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop phase skipped");
	property p_idle;
		seq && !MOTOR_POWER_ON |-> BRAKE_HOLD_OUTPUT;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle brake not high");
endmodule : hbs_brake_seq_sva

bind hbs_brake_seq hbs_brake_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SERVO_ON_INPUT(SERVO_ON_INPUT),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.BRAKE_HOLD_OUTPUT(BRAKE_HOLD_OUTPUT), .MOTOR_POWER_ON(MOTOR_POWER_ON),
	.MOTION_ENABLE(MOTION_ENABLE));

// ### test/hbs_brake_model.sv
`timescale 1ns/10ps
// brake mechanics: frees the shaft only after a release lag
module hbs_brake_model #(
	parameter int LAG = 3
) (
	input wire logic clk,
	input wire logic brake_cmd,
	output logic shaft_free
);
	int cnt_r;
	int cnt_nxt;
	// high closes at once, low frees after LAG cycles
	always_comb begin
		cnt_nxt = brake_cmd ? 0 : (cnt_r < LAG ? cnt_r + 1 : cnt_r);
	end
	always_ff @(posedge clk) begin
		cnt_r <= cnt_nxt;
	end
	assign shaft_free = (cnt_r >= LAG);
endmodule : hbs_brake_model

// ### test/test_hbs_brake_seq.sv
`timescale 1ns/10ps
module test_hbs_brake_seq;
	localparam int TK = 4;
	logic SYS_CLK = 1'b0;
	logic SYS_RST;
	logic SERVO_ON_INPUT;
	logic [7:0] REG_ADDR;
	logic [31:0] REG_WDATA;
	logic REG_WR;
	logic REG_RD;
	logic [31:0] REG_RDATA;
	logic BRAKE_HOLD_OUTPUT;
	logic MOTOR_POWER_ON;
	logic MOTION_ENABLE;
	logic shaft_free;
	int err_total;
	int comparisons;
	int n;
	always #10 SYS_CLK = ~SYS_CLK;
	hbs_brake_seq #(.TICK_CYCLES(TK)) dut (.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST), .SERVO_ON_INPUT(SERVO_ON_INPUT),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.BRAKE_HOLD_OUTPUT(BRAKE_HOLD_OUTPUT),
		.MOTOR_POWER_ON(MOTOR_POWER_ON), .MOTION_ENABLE(MOTION_ENABLE));
	hbs_brake_model u_brake (.clk(SYS_CLK), .brake_cmd(BRAKE_HOLD_OUTPUT),
		.shaft_free(shaft_free));
	////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask : wr
	// data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 check("rdata", REG_RDATA, exp);
	endtask : rd
	task servo(input logic v);
		@(posedge SYS_CLK);
		SERVO_ON_INPUT <= v;
		#1;
	endtask : servo
	// bounded wait; output 0 brake, 1 power, 2 motion
	task wait_out(input int sel, input logic lvl);
		logic [2:0] o;
		n = 0;
		o = {MOTION_ENABLE, MOTOR_POWER_ON, BRAKE_HOLD_OUTPUT};
		while (o[sel] !== lvl && n < 400) begin
			@(posedge SYS_CLK);
			#1 n++;
			o = {MOTION_ENABLE, MOTOR_POWER_ON, BRAKE_HOLD_OUTPUT};
		end
	endtask : wait_out
	// the tick phase costs up to two cycles either way
	task near(input string what, input int exp);
		check(what, {31'h0, n >= exp - 2 && n <= exp + 2}, 32'h1);
	endtask : near
	task outs(input logic [2:0] exp);
		check("outs", {MOTION_ENABLE, MOTOR_POWER_ON, BRAKE_HOLD_OUTPUT}, exp);
	endtask : outs
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		outs(3'b001);
		rd(hbs_pkg::OFS_CONFIG, 32'h0);
		rd(hbs_pkg::OFS_OPEN_DLY, 32'h64);
		rd(hbs_pkg::OFS_CLOSE_DLY, 32'h64);
		rd(hbs_pkg::OFS_ZS_MON, 32'hc8);
		rd(hbs_pkg::OFS_PULSE_SUP, 32'h64);
		wr(hbs_pkg::OFS_STATUS, 32'hff);
		rd(hbs_pkg::OFS_STATUS, 32'h20);
		rd(8'h18, 32'h0);
	endtask : t_reset
	task t_clamp;
		wr(hbs_pkg::OFS_OPEN_DLY, 32'hffffffff);
		rd(hbs_pkg::OFS_OPEN_DLY, 32'h2710);
		wr(hbs_pkg::OFS_CLOSE_DLY, 32'h2711);
		rd(hbs_pkg::OFS_CLOSE_DLY, 32'h2710);
		wr(hbs_pkg::OFS_CLOSE_DLY, 32'h270f);
		rd(hbs_pkg::OFS_CLOSE_DLY, 32'h270f);
	endtask : t_clamp
	// configs without sequencing: brake fixed, power follows servo-on
	task t_modes;
		logic [1:0] c;
		for (int i = 0; i < 3; i++) begin
			c = (i == 0) ? 2'h0 : (i == 1 ? 2'h2 : 2'h3);
			wr(hbs_pkg::OFS_CONFIG, {30'h0, c});
			rd(hbs_pkg::OFS_CONFIG, {30'h0, c});
			servo(1'b1);
			repeat (8) @(posedge SYS_CLK);
			#1 outs({2'b11, c != 2'h2});
			servo(1'b0);
			repeat (8) @(posedge SYS_CLK);
			#1 outs({2'b00, c != 2'h2});
		end
	endtask : t_modes
	task t_seq(input int op, input int cl, input int zs, input int ps);
		wr(hbs_pkg::OFS_OPEN_DLY, op);
		wr(hbs_pkg::OFS_CLOSE_DLY, cl);
		wr(hbs_pkg::OFS_ZS_MON, zs);
		wr(hbs_pkg::OFS_PULSE_SUP, ps);
		wr(hbs_pkg::OFS_CONFIG, 32'h1);
		servo(1'b1);
		wait_out(1, 1'b1);
		outs(3'b010);
		wait_out(2, 1'b1);
		near("open", op * TK + 1);
		check("shaft", shaft_free, 1'b1);
		servo(1'b0);
		wait_out(2, 1'b0);
		outs(3'b010);
		wait_out(0, 1'b1);
		near("close start", (zs < ps ? zs : ps) * TK + 1);
		check("power", MOTOR_POWER_ON, 1'b1);
		wait_out(1, 1'b0);
		near("close", cl * TK + 1);
		outs(3'b001);
		check("shaft shut", shaft_free, 1'b0);
	endtask : t_seq
	// a rising edge while stopping is not queued: brake stays closed
	task t_refuse;
		wr(hbs_pkg::OFS_OPEN_DLY, 32'h0);
		wr(hbs_pkg::OFS_CLOSE_DLY, 32'h1);
		wr(hbs_pkg::OFS_ZS_MON, 32'h3);
		wr(hbs_pkg::OFS_PULSE_SUP, 32'h3);
		servo(1'b1);
		wait_out(2, 1'b1);
		servo(1'b0);
		wait_out(2, 1'b0);
		servo(1'b1);
		wait_out(1, 1'b0);
		repeat (8) @(posedge SYS_CLK);
		#1 outs(3'b001);
		servo(1'b0);
		repeat (8) @(posedge SYS_CLK);
		#1 outs(3'b001);
	endtask : t_refuse
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	initial begin
		SYS_RST = 1'b1;
		SERVO_ON_INPUT = 1'b0;
		REG_ADDR = 8'h0;
		REG_WDATA = 32'h0;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (12) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		@(posedge SYS_CLK);
		#1 t_reset();
		t_clamp();
		t_modes();
		t_seq(2, 3, 5, 2);
		t_seq(1, 0, 1, 6);
		t_refuse();
		tally_and_finish();
	end
	// every scenario ends well inside this span
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		err_total++;
		tally_and_finish();
	end
endmodule : test_hbs_brake_seq
